// ### hdl/fir_cfg_pkg.sv
// Constants, register map and carrier types of the FIR channel config block.
// Assumes a 32-bit Avalon-MM master using word addresses.
package fir_cfg_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NCH = 4;
   localparam int NTAP = 8;
   localparam int DW = 24;
   localparam int CW = 16;
   localparam int AW = 40;
   localparam int COEF_FRAC = 15;

   // ****************************************
   // Register word indices (byte address = 4 * index)
   // ****************************************
   localparam logic [3:0] REG_CHAN_SEL = 4'h0;
   localparam logic [3:0] REG_OP_MASK = 4'h1;
   localparam logic [3:0] REG_DEC_RATIO = 4'h2;
   localparam logic [3:0] REG_TAP_COUNT = 4'h3;
   localparam logic [3:0] REG_COEF_INDEX = 4'h4;
   localparam logic [3:0] REG_COEF_DATA = 4'h5;
   localparam logic [3:0] REG_COMMAND = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_CHAN_CFG0 = 4'h8;
   localparam logic [3:0] REG_AVG_FACTOR = 4'hC;

   // ****************************************
   // Operation mask bits and channel selector values
   // ****************************************
   localparam int MSK_ENABLE = 0;
   localparam int MSK_DECIM = 1;
   localparam int MSK_LOAD = 2;
   localparam int MSK_DEFAULT = 3;
   localparam int MSK_ORDER = 4;
   localparam int CMD_APPLY = 0;
   localparam logic [3:0] SEL_CH0 = 4'h1;
   localparam logic [3:0] SEL_ALL = 4'hF;

   // ****************************************
   // Limits and reset values
   // ****************************************
   localparam logic [15:0] DEC_MAX = 16'h03FF;
   localparam logic [15:0] DEC_RST = 16'h0000;
   localparam logic [3:0] TAPS_DEF = 4'h8;
   localparam logic [3:0] TAPS_MAX = 4'h8;
   localparam logic [15:0] COEF_DEF = 16'h1000;

   typedef struct packed {
      logic [1:0] ch;
      logic [DW-1:0] data;
   } sample_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } av_req_s;

   typedef struct packed {
      logic en;
      logic after_avg;
      logic [3:0] taps;
      logic [15:0] dec;
      logic [NTAP-1:0][CW-1:0] coef;
   } chan_cfg_s;

   // Default filter: eight equal taps of 1/8, unity gain at DC
   localparam chan_cfg_s CFG_DEF = '{en: 1'b1, after_avg: 1'b0,
      taps: TAPS_DEF, dec: DEC_RST, coef: {NTAP{COEF_DEF}}};

endpackage : fir_cfg_pkg

// ### hdl/fir_cfg.sv
// Per-channel FIR, averaging and decimation with an Avalon-MM register port.
// Assumes samples arrive on clk, at most one per cycle, from logic on clk.
`timescale 1ns/10ps

module fir_cfg (
   input wire logic clk,
   input wire logic rst_n,
   input wire fir_cfg_pkg::av_req_s bus_in,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic in_valid,
   input wire fir_cfg_pkg::sample_s in_sample,
   output logic out_valid,
   output fir_cfg_pkg::sample_s out_sample
);

   typedef struct packed {
      fir_cfg_pkg::chan_cfg_s [fir_cfg_pkg::NCH-1:0] cfg;
      logic [fir_cfg_pkg::NCH-1:0][fir_cfg_pkg::NTAP-1:0][23:0] hist;
      logic [fir_cfg_pkg::NCH-1:0][39:0] acc;
      logic [fir_cfg_pkg::NCH-1:0][14:0] acnt;
      logic [fir_cfg_pkg::NCH-1:0][15:0] dcnt;
      logic [3:0] sel;
      logic [4:0] mask;
      logic [15:0] dec;
      logic [3:0] taps;
      logic [2:0] cidx;
      logic [fir_cfg_pkg::NTAP-1:0][15:0] stage;
      logic [3:0] avgf;
      logic rejected;
      logic accepted;
      logic ack;
      logic [31:0] rdata;
      logic ovalid;
      fir_cfg_pkg::sample_s osample;
   } state_s;

   state_s s_r;
   state_s s_nxt;
   logic [1:0] rsync_r;
   logic rst_s;
   logic req;
   logic take;
   logic apply;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [23:0] fir_calc(
      input logic [fir_cfg_pkg::NTAP-1:0][23:0] h,
      input logic [fir_cfg_pkg::NTAP-1:0][15:0] c,
      input logic [3:0] n);
      logic signed [42:0] s;
      s = '0;
      for (int k = 0; k < fir_cfg_pkg::NTAP; k++) begin
         if (4'(k) < n) begin
            s = s + 43'(signed'(h[k]) * signed'(c[k]));
         end
      end
      return s[fir_cfg_pkg::COEF_FRAC +: 24];
   endfunction : fir_calc

   function automatic logic cmd_bad(input logic [3:0] sel,
      input logic [4:0] mask, input logic [3:0] taps,
      input logic [15:0] dec);
      logic def;
      def = mask[fir_cfg_pkg::MSK_DEFAULT];
      return (sel == 4'h0)
         || (!def && mask[fir_cfg_pkg::MSK_LOAD]
             && (taps == 4'h0 || taps > fir_cfg_pkg::TAPS_MAX))
         || (!def && mask[fir_cfg_pkg::MSK_DECIM]
             && dec > fir_cfg_pkg::DEC_MAX);
   endfunction : cmd_bad

   // ****************************************
   // Reset release
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsync_r <= 2'h0;
      end else begin
         rsync_r <= {rsync_r[0], 1'b1};
      end
   end
   assign rst_s = rsync_r[1];

   // Every access gets exactly one wait cycle; read data is fetched then
   assign req = bus_in.read | bus_in.write;
   assign take = req & s_r.ack;
   assign apply = take & bus_in.write
      & (bus_in.address == fir_cfg_pkg::REG_COMMAND)
      & bus_in.writedata[fir_cfg_pkg::CMD_APPLY];
   assign waitrequest = req & ~s_r.ack;
   assign readdata = s_r.rdata;
   assign out_valid = s_r.ovalid;
   assign out_sample = s_r.osample;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [1:0] c;
      logic [23:0] x;
      logic [23:0] ain;
      logic [23:0] aout;
      logic [23:0] fin;
      logic signed [39:0] sum;
      logic [14:0] alim;
      logic done;
      logic [fir_cfg_pkg::NTAP-1:0][23:0] h1;
      logic [fir_cfg_pkg::NTAP-1:0][23:0] h2;
      fir_cfg_pkg::chan_cfg_s cf;
      c = in_sample.ch;
      x = in_sample.data;
      cf = s_r.cfg[c];
      ain = '0;
      aout = '0;
      fin = '0;
      sum = '0;
      alim = '0;
      done = 1'b0;
      h1 = '0;
      h2 = '0;
      s_nxt = s_r;
      s_nxt.ack = req & ~s_r.ack;
      s_nxt.ovalid = 1'b0;

      // Register reads, latched in the wait cycle
      if (req && !s_r.ack) begin
         s_nxt.rdata = '0;
         case (bus_in.address)
            fir_cfg_pkg::REG_CHAN_SEL: s_nxt.rdata[3:0] = s_r.sel;
            fir_cfg_pkg::REG_OP_MASK: s_nxt.rdata[4:0] = s_r.mask;
            fir_cfg_pkg::REG_DEC_RATIO: s_nxt.rdata[15:0] = s_r.dec;
            fir_cfg_pkg::REG_TAP_COUNT: s_nxt.rdata[3:0] = s_r.taps;
            fir_cfg_pkg::REG_COEF_INDEX: s_nxt.rdata[2:0] = s_r.cidx;
            fir_cfg_pkg::REG_COEF_DATA:
               s_nxt.rdata[15:0] = s_r.stage[s_r.cidx];
            fir_cfg_pkg::REG_STATUS:
               s_nxt.rdata[1:0] = {s_r.accepted, s_r.rejected};
            fir_cfg_pkg::REG_AVG_FACTOR: s_nxt.rdata[3:0] = s_r.avgf;
            default: begin
               if (bus_in.address[3:2] == 2'h2) begin
                  cf = s_r.cfg[bus_in.address[1:0]];
                  s_nxt.rdata = {cf.dec, 8'h00, cf.taps, 2'h0,
                     cf.after_avg, cf.en};
                  cf = s_r.cfg[c];
               end
            end
         endcase
      end

      // Register writes take effect on the edge that ends the cycle after the wait
      if (take && bus_in.write) begin
         case (bus_in.address)
            fir_cfg_pkg::REG_CHAN_SEL: s_nxt.sel = bus_in.writedata[3:0];
            fir_cfg_pkg::REG_OP_MASK: s_nxt.mask = bus_in.writedata[4:0];
            fir_cfg_pkg::REG_DEC_RATIO: s_nxt.dec = bus_in.writedata[15:0];
            fir_cfg_pkg::REG_TAP_COUNT: s_nxt.taps = bus_in.writedata[3:0];
            fir_cfg_pkg::REG_COEF_INDEX:
               s_nxt.cidx = bus_in.writedata[2:0];
            fir_cfg_pkg::REG_COEF_DATA:
               s_nxt.stage[s_r.cidx] = bus_in.writedata[15:0];
            fir_cfg_pkg::REG_AVG_FACTOR: begin
               s_nxt.avgf = bus_in.writedata[3:0];
               s_nxt.acc = '0;
               s_nxt.acnt = '0;
            end
            default: begin
            end
         endcase
      end

      // Apply staged configuration to the selected channels
      if (apply) begin
         if (cmd_bad(s_r.sel, s_r.mask, s_r.taps, s_r.dec)) begin
            s_nxt.rejected = 1'b1;
            s_nxt.accepted = 1'b0;
         end else begin
            s_nxt.rejected = 1'b0;
            s_nxt.accepted = 1'b1;
            for (int i = 0; i < fir_cfg_pkg::NCH; i++) begin
               if (s_r.sel[i]) begin
                  s_nxt.dcnt[i] = '0;
                  if (s_r.mask[fir_cfg_pkg::MSK_DEFAULT]) begin
                     s_nxt.cfg[i] = fir_cfg_pkg::CFG_DEF;
                  end else begin
                     if (s_r.mask[fir_cfg_pkg::MSK_LOAD]) begin
                        s_nxt.cfg[i].taps = s_r.taps;
                        s_nxt.cfg[i].coef = s_r.stage;
                     end
                     // Unflagged taps and ratio stay as they are; en and after_avg always take their mask bits
                     if (s_r.mask[fir_cfg_pkg::MSK_DECIM]) begin
                        s_nxt.cfg[i].dec = s_r.dec;
                     end
                     s_nxt.cfg[i].en = s_r.mask[fir_cfg_pkg::MSK_ENABLE];
                     s_nxt.cfg[i].after_avg =
                        s_r.mask[fir_cfg_pkg::MSK_ORDER];
                  end
               end
            end
         end
      end

      // Sample path; the whole chain settles within one cycle
      if (in_valid) begin
         h1 = {s_r.hist[c][fir_cfg_pkg::NTAP-2:0], x};
         if (!cf.after_avg) begin
            s_nxt.hist[c] = h1;
            ain = cf.en ? fir_calc(h1, cf.coef, cf.taps) : x;
         end else begin
            ain = x;
         end
         sum = signed'(s_r.acc[c]) + 40'(signed'(ain));
         alim = 15'((32'h1 << s_r.avgf) - 32'h1);
         done = (s_r.acnt[c] == alim);
         if (done) begin
            aout = 24'(sum >>> s_r.avgf);
            s_nxt.acc[c] = '0;
            s_nxt.acnt[c] = '0;
         end else begin
            s_nxt.acc[c] = sum;
            s_nxt.acnt[c] = s_r.acnt[c] + 15'h1;
         end
         fin = aout;
         if (cf.after_avg && done) begin
            h2 = {s_r.hist[c][fir_cfg_pkg::NTAP-2:0], aout};
            s_nxt.hist[c] = h2;
            fin = cf.en ? fir_calc(h2, cf.coef, cf.taps) : aout;
         end
         // Keep one reading, then drop the next dec readings
         if (done) begin
            if (s_r.dcnt[c] == 16'h0) begin
               s_nxt.ovalid = 1'b1;
               s_nxt.osample = '{ch: c, data: fin};
               s_nxt.dcnt[c] = cf.dec;
            end else begin
               s_nxt.dcnt[c] = s_r.dcnt[c] - 16'h1;
            end
         end
      end
   end

   // Default filter, filter-first order and zero ratio out of reset
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         s_r <= '0;
         s_r.cfg <= {fir_cfg_pkg::NCH{fir_cfg_pkg::CFG_DEF}};
         s_r.taps <= fir_cfg_pkg::TAPS_DEF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_s)
      req && waitrequest |=> !waitrequest)
      else $error("bus wait longer than one cycle");
   a_reset_default: assert property (@(posedge clk)
      $rose(rst_s) |-> s_r.cfg[0] == fir_cfg_pkg::CFG_DEF
         && s_r.cfg[3].dec == 16'h0)
      else $error("channel not default after reset");
   a_reject_keep: assert property (@(posedge clk) disable iff (!rst_s)
      apply && s_r.sel == 4'h0 |=> s_r.rejected && $stable(s_r.cfg))
      else $error("empty selection changed settings");
   a_restore_def: assert property (@(posedge clk) disable iff (!rst_s)
      apply && s_r.sel[0] && s_r.mask[fir_cfg_pkg::MSK_DEFAULT]
      |=> s_r.cfg[0] == fir_cfg_pkg::CFG_DEF)
      else $error("restore did not give default filter");
   a_load_taps: assert property (@(posedge clk) disable iff (!rst_s)
      apply && s_r.sel[1] && !cmd_bad(s_r.sel, s_r.mask, s_r.taps, s_r.dec)
      && s_r.mask[fir_cfg_pkg::MSK_DEFAULT:fir_cfg_pkg::MSK_LOAD] == 2'b01
      |=> s_r.cfg[1].taps == $past(s_r.taps)
         && s_r.cfg[1].coef == $past(s_r.stage))
      else $error("coefficients not loaded");
   a_dec_keep: assert property (@(posedge clk) disable iff (!rst_s)
      apply && !s_r.mask[fir_cfg_pkg::MSK_DECIM]
      && !s_r.mask[fir_cfg_pkg::MSK_DEFAULT]
      |=> $stable(s_r.cfg[2].dec))
      else $error("ratio changed without its flag");
   a_mode_bits: assert property (@(posedge clk) disable iff (!rst_s)
      apply && s_r.sel[0] && !cmd_bad(s_r.sel, s_r.mask, s_r.taps, s_r.dec)
      && !s_r.mask[fir_cfg_pkg::MSK_DEFAULT]
      |=> s_r.cfg[0].en == $past(s_r.mask[fir_cfg_pkg::MSK_ENABLE])
         && s_r.cfg[0].after_avg ==
            $past(s_r.mask[fir_cfg_pkg::MSK_ORDER]))
      else $error("enable or order bit not applied");
   a_plain_pass: assert property (@(posedge clk) disable iff (!rst_s)
      in_valid && s_r.avgf == 4'h0 && !s_r.cfg[in_sample.ch].en
      && s_r.dcnt[in_sample.ch] == 16'h0 && !apply
      |=> out_valid && out_sample == $past(in_sample))
      else $error("bypassed sample not passed through");
   a_decim_drop: assert property (@(posedge clk) disable iff (!rst_s)
      out_valid && out_sample.ch == 2'h0 && s_r.cfg[0].dec != 16'h0
      && !$past(apply) |-> s_r.dcnt[0] == s_r.cfg[0].dec)
      else $error("drop count not loaded after a kept reading");
   a_decim_next: assert property (@(posedge clk) disable iff (!rst_s)
      in_valid && in_sample.ch == 2'h0 && s_r.dcnt[0] != 16'h0
      && s_r.avgf == 4'h0 && !apply |=> !out_valid)
      else $error("reading while counting down not dropped");

endmodule : fir_cfg

// ### verif/host_model.sv
// Avalon-MM master standing in for host configuration software.
// Assumes a slave on clk; only the bench watchdog ends a wait.
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   output fir_cfg_pkg::av_req_s bus
);
   initial begin
      bus = '0;
   end
   // ****
   // One transfer, held until waitrequest is seen low
   // ****
   task automatic xfer(input logic rd, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      bus <= '{read: rd, write: ~rd, address: a, writedata: d};
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      bus <= '0;
   endtask : xfer
endmodule : host_model

// ### verif/testbench.sv
// Self-checking bench for the FIR channel config block.
// Assumes the register map and reset values of fir_cfg_pkg.
`timescale 1ns/10ps
module testbench;
   logic clk;
   logic rst_n;
   fir_cfg_pkg::av_req_s bus;
   logic [31:0] readdata;
   logic waitrequest;
   logic in_valid;
   fir_cfg_pkg::sample_s in_sample;
   logic out_valid;
   fir_cfg_pkg::sample_s out_sample;
   fir_cfg_pkg::sample_s exp_q[$];
   int n_mismatch;
   int cmp_count;
   logic [23:0] d;
   int v;

   fir_cfg fir_cfg_i (.clk(clk), .rst_n(rst_n), .bus_in(bus),
      .readdata(readdata), .waitrequest(waitrequest),
      .in_valid(in_valid), .in_sample(in_sample),
      .out_valid(out_valid), .out_sample(out_sample));
   host_model host_model_i (.clk(clk), .readdata(readdata),
      .waitrequest(waitrequest), .bus(bus));

   always #20 clk = ~clk;

   // ****
   // Compare, bus and stream helpers
   // ****
   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t reg got %h exp %h", $time, g, e);
      end
   endtask : cmp_reg
   task automatic cmp_smp(input logic [25:0] g, input logic [25:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t out got %h exp %h", $time, g, e);
      end
   endtask : cmp_smp
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      logic [31:0] q;
      host_model_i.xfer(1'b0, a, x, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      host_model_i.xfer(1'b1, a, 32'h0, q);
      cmp_reg(q, e);
   endtask : rd
   task automatic apply(input logic [3:0] sel, input logic [4:0] m,
      input logic [15:0] dec, input logic [3:0] taps);
      wr(fir_cfg_pkg::REG_CHAN_SEL, {28'h0, sel});
      wr(fir_cfg_pkg::REG_OP_MASK, {27'h0, m});
      wr(fir_cfg_pkg::REG_DEC_RATIO, {16'h0, dec});
      wr(fir_cfg_pkg::REG_TAP_COUNT, {28'h0, taps});
      wr(fir_cfg_pkg::REG_COMMAND, 32'h1);
   endtask : apply
   // Expectation is queued before the sample can produce it
   task automatic send(input logic [1:0] ch, input logic [23:0] x,
      input logic keep, input logic [23:0] y);
      if (keep) exp_q.push_back('{ch: ch, data: y});
      @(posedge clk);
      in_valid <= 1'b1;
      in_sample <= '{ch: ch, data: x};
      @(posedge clk);
      in_valid <= 1'b0;
   endtask : send
   function automatic logic [31:0] cfg(input logic [15:0] dec,
      input logic [3:0] taps, input logic aa, input logic en);
      return {dec, 8'h00, taps, 2'b00, aa, en};
   endfunction : cfg
   // One tap of 0x7FFF, signed product shifted down by 15
   function automatic logic [23:0] near1(input logic [23:0] x);
      longint p;
      p = longint'($signed(x)) * 32767;
      return 24'(p >>> 15);
   endfunction : near1
   task automatic tally_and_finish;
      if (exp_q.size() != 0) n_mismatch++;
      $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // ****
   // Output watcher and watchdog
   // ****
   always @(posedge clk) begin
      if (out_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t out got %h exp %h", $time,
               out_sample, 26'h0);
         end else begin
            cmp_smp(out_sample, exp_q.pop_front());
         end
      end
   end
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish();
   end

   // ****
   // Main sequence
   // ****
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      in_valid = 1'b0;
      in_sample = '0;
      n_mismatch = 0;
      cmp_count = 0;
      void'($urandom(32'h915E));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(4'h8 + 4'(i), cfg(16'h0, 4'h8, 1'b0, 1'b1));
      end
      rd(4'hF, 32'h0);
      // Bypass channel zero only
      apply(fir_cfg_pkg::SEL_CH0, 5'h00, 16'h0, 4'h8);
      rd(fir_cfg_pkg::REG_STATUS, 32'h2);
      rd(fir_cfg_pkg::REG_CHAN_CFG0, cfg(16'h0, 4'h8, 1'b0, 1'b0));
      rd(4'h9, cfg(16'h0, 4'h8, 1'b0, 1'b1));
      d = 24'($urandom);
      send(2'd0, d, 1'b1, d);
      // Ratio two keeps one reading of every three
      apply(fir_cfg_pkg::SEL_CH0, 5'h02, 16'h2, 4'h8);
      rd(fir_cfg_pkg::REG_CHAN_CFG0, cfg(16'h2, 4'h8, 1'b0, 1'b0));
      for (int i = 0; i < 6; i++) begin
         d = 24'($urandom);
         send(2'd0, d, i == 0 || i == 3, d);
      end
      // Empty selection, too many taps, ratio past the limit
      apply(4'h0, 5'h01, 16'h0, 4'h8);
      rd(fir_cfg_pkg::REG_STATUS, 32'h1);
      apply(fir_cfg_pkg::SEL_ALL, 5'h04, 16'h0, 4'h9);
      rd(fir_cfg_pkg::REG_STATUS, 32'h1);
      apply(fir_cfg_pkg::SEL_CH0, 5'h02, 16'h0400, 4'h8);
      rd(fir_cfg_pkg::REG_STATUS, 32'h1);
      rd(fir_cfg_pkg::REG_CHAN_CFG0, cfg(16'h2, 4'h8, 1'b0, 1'b0));
      rd(fir_cfg_pkg::REG_DEC_RATIO, 32'h400);
      rd(fir_cfg_pkg::REG_OP_MASK, 32'h2);
      wr(fir_cfg_pkg::REG_COEF_INDEX, 32'h0);
      wr(fir_cfg_pkg::REG_COEF_DATA, 32'h7FFF);
      rd(fir_cfg_pkg::REG_COEF_DATA, 32'h7FFF);
      apply(4'h2, 5'h05, 16'h0, 4'h1);
      rd(4'h9, cfg(16'h0, 4'h1, 1'b0, 1'b1));
      d = 24'($urandom) & 24'h7FFFFF;
      send(2'd1, d, 1'b1, near1(d));
      // Restore wins over a bad ratio and the order flag
      apply(fir_cfg_pkg::SEL_ALL, 5'h1A, 16'h07FF, 4'h0);
      rd(fir_cfg_pkg::REG_STATUS, 32'h2);
      for (int i = 0; i < 4; i++) begin
         rd(4'h8 + 4'(i), cfg(16'h0, 4'h8, 1'b0, 1'b1));
      end
      v = 8 * $urandom_range(1, 1000);
      for (int i = 0; i < 10; i++) begin
         send(2'd2, 24'(v), 1'b1, 24'((i < 8 ? i + 1 : 8) * v / 8));
      end
      // Order shows in truncation of -1 and 4 through one tap
      wr(fir_cfg_pkg::REG_AVG_FACTOR, 32'h1);
      rd(fir_cfg_pkg::REG_AVG_FACTOR, 32'h1);
      apply(4'h8, 5'h05, 16'h0, 4'h1);
      send(2'd3, 24'hFFFFFF, 1'b0, 24'h0);
      send(2'd3, 24'h000004, 1'b1, 24'h000001);
      apply(4'h8, 5'h15, 16'h0, 4'h1);
      rd(4'hB, cfg(16'h0, 4'h1, 1'b1, 1'b1));
      send(2'd3, 24'hFFFFFF, 1'b0, 24'h0);
      send(2'd3, 24'h000004, 1'b1, 24'h000000);
      repeat (10) @(posedge clk);
      tally_and_finish();
   end
endmodule : testbench
